// [testbench/porm_chk.sv]
/*
 * Checker for the port option block: bus handshakes, pad outputs, wake.
 * Assumes it is bound onto the top and that full words are written
 * with address and data offered together.
 */
`timescale 1ns/1ps
module porm_chk (
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire logic [porm_pkg::AW-1:0]   s_axi_awaddr,
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_awready,
    input wire logic [porm_pkg::DW-1:0]   s_axi_wdata,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_wready,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic [porm_pkg::AW-1:0]   s_axi_araddr,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire logic [porm_pkg::DW-1:0]   s_axi_rdata,
    input wire logic [1:0]                s_axi_rresp,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire logic [porm_pkg::NIB-1:0]  pe_oe_n,
    input wire logic [porm_pkg::NIB-1:0]  pc_out,
    input wire logic [porm_pkg::NIB-1:0]  pd_out,
    input wire logic                      halt,
    input wire logic                      wake_req
);
    porm_pkg::porm_opt_s  opt_sh;
    porm_pkg::porm_opt_s  next_opt_sh;
    logic [1:0]           age;
    logic [1:0]           next_age;
    logic                 wr_take;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Shadow of the last option word and cycles since a write
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_comb begin
        next_opt_sh = opt_sh;
        next_age = (age == 2'h3) ? age : age + 2'h1;
        if (wr_take) begin
            next_age = 2'h0;
            if (s_axi_awaddr == porm_pkg::ADDR_OPTION) begin
                next_opt_sh = porm_pkg::porm_opt_s'(s_axi_wdata[porm_pkg::OPT_W-1:0]);
            end
        end
        if (rst) begin
            next_opt_sh = '0;
            next_age = 2'h3;
        end
    end
    always_ff @(posedge mclk) begin
        opt_sh <= next_opt_sh;
        age <= next_age;
    end

    a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > porm_pkg::ADDR_PADS
        |=> s_axi_rresp == porm_pkg::RESP_SLVERR && s_axi_rdata == porm_pkg::WORD_ZERO)
        else $error("unmapped read answered wrongly");
    a_force_c_high: assert property (age == 2'h3 |-> (pc_out & opt_sh.port_c_force_high_option)
        == opt_sh.port_c_force_high_option) else $error("port c force high lost");
    a_force_d_high: assert property (age == 2'h3 |-> (pd_out & opt_sh.port_d_force_high_option)
        == opt_sh.port_d_force_high_option) else $error("port d force high lost");
    a_input_only: assert property (age == 2'h3 && !opt_sh.port_e_bidir_option |-> pe_oe_n == 4'hF)
        else $error("port e driven in input mode");
    a_wake_idle: assert property (!halt && !$past(halt) |-> !wake_req)
        else $error("wake request outside halt");

    c_write: cover property (wr_take);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_wake: cover property ($rose(wake_req));
endmodule

bind porm_port_option_read_mux porm_chk i_chk (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pe_oe_n,
    .pc_out, .pd_out, .halt, .wake_req);

// [testbench/port_option_read_mux_tb.sv]
/*
 * Bench for the port option block: bus tasks, read-mux table, pad outputs, wake.
 * Assumes the checker is bound from its own file; the bench drives every port.
 */
`timescale 1ns/1ps
module port_option_read_mux_tb;
    localparam logic [1:0]        OK  = porm_pkg::RESP_OKAY;
    localparam logic [1:0]        ERR = porm_pkg::RESP_SLVERR;
    logic                         mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic                         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                         s_axi_rvalid, cmp1_out, cmp2_out, halt, wake_req;
    logic [porm_pkg::AW-1:0]      s_axi_awaddr, s_axi_araddr;
    logic [porm_pkg::DW-1:0]      s_axi_wdata, s_axi_rdata;
    logic [1:0]                   s_axi_bresp, s_axi_rresp;
    logic [3:0]                   s_axi_wstrb;
    logic [porm_pkg::NIB-1:0]     pa_in, pb_in, pd_in, pe_in, pe_out, pe_oe_n, pc_out, pd_out;
    int                           err_total;
    int                           checked;

    porm_port_option_read_mux i_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pa_in, .pb_in, .pd_in, .pe_in, .cmp1_out, .cmp2_out, .pe_out, .pe_oe_n, .pc_out, .pd_out, .halt, .wake_req);

    // Clock of 100 ns
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Write one word; sample at the falling edge, act after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input string nm);
        logic aw_t, w_t, b_v, b_t, done;
        logic [1:0] r;
        done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        while (!done) begin
            @(negedge mclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_v = s_axi_bvalid;
            b_t = b_v && s_axi_bready;
            r = s_axi_bresp;
            @(posedge mclk);
            if (aw_t)
                s_axi_awvalid <= 1'h0;
            if (w_t)
                s_axi_wvalid <= 1'h0;
            if (b_v && !b_t)
                s_axi_bready <= 1'h1;
            if (b_t) begin
                s_axi_bready <= 1'h0;
                done = 1'h1;
            end
        end
        chk(nm, {30'h0, er}, {30'h0, r});
    endtask

    // Read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
        logic ar_t, r_v, r_t, done;
        logic [31:0] d;
        logic [1:0] r;
        done = 1'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (!done) begin
            @(negedge mclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_v = s_axi_rvalid;
            r_t = r_v && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ar_t)
                s_axi_arvalid <= 1'h0;
            if (r_v && !r_t)
                s_axi_rready <= 1'h1;
            if (r_t) begin
                s_axi_rready <= 1'h0;
                done = 1'h1;
            end
        end
        chk(nm, e, d);
        chk(nm, {30'h0, er}, {30'h0, r});
    endtask

    // Compare port E enables, port E data, port D and port C outputs
    task automatic pins(input string nm, input logic [15:0] e);
        @(negedge mclk);
        chk(nm, {16'h0, e}, {16'h0, pe_oe_n, pe_out, pd_out, pc_out});
        @(posedge mclk);
    endtask

    // Set options and pads, let the filter settle, read port E
    task automatic mux(input logic [31:0] opt, input logic [3:0] p, input logic c1, input logic c2,
                       input logic [3:0] e);
        wr(porm_pkg::ADDR_OPTION, opt, OK, "option");
        pe_in <= p;
        cmp1_out <= c1;
        cmp2_out <= c2;
        repeat (6) @(posedge mclk);
        rd(porm_pkg::ADDR_E_DATA, {28'h0, e}, OK, "port e read");
    endtask

    // Hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude();
    end

    // Main sequence
    initial begin
        err_total = 0;
        checked = 0;
        rst = 1'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, halt} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {pa_in, pb_in, pd_in, pe_in, cmp1_out, cmp2_out} = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        pins("pins reset", 16'hF000);
        rd(porm_pkg::ADDR_OPTION, 32'h0, OK, "option reset");
        rd(porm_pkg::ADDR_E_DIR, 32'h0, OK, "direction reset");
        rd(8'h18, 32'h0, ERR, "unmapped read");
        wr(8'h18, 32'hFFFF_FFFF, ERR, "unmapped write");
        wr(porm_pkg::ADDR_PADS, 32'hFFFF_FFFF, OK, "pads write");
        mux(32'h18, 4'hF, 1'h1, 1'h1, 4'hF);
        mux(32'h03, 4'hF, 1'h0, 1'h1, 4'h2);
        mux(32'h03, 4'h0, 1'h1, 1'h1, 4'h1);
        mux(32'h0B, 4'hF, 1'h1, 1'h1, 4'h1);
        mux(32'h14, 4'hF, 1'h1, 1'h0, 4'h3);
        mux(32'h06, 4'hF, 1'h0, 1'h1, 4'hE);
        wr(porm_pkg::ADDR_OPTION, 32'h20, OK, "option");
        wr(porm_pkg::ADDR_E_DIR, 32'h5, OK, "direction");
        wr(porm_pkg::ADDR_E_DATA, 32'hC, OK, "port e data");
        pins("pins bidir", 16'hAC00);
        wr(porm_pkg::ADDR_OPTION, 32'h0, OK, "option");
        pins("pins input only", 16'hFC00);
        wr(porm_pkg::ADDR_CD_DATA, 32'h21, OK, "port c d data");
        pins("pins latch", 16'hFC21);
        wr(porm_pkg::ADDR_OPTION, 32'h1280, OK, "option");
        pins("pins force high", 16'hFC6B);
        wr(porm_pkg::ADDR_WAKE_EN, 32'h1000, OK, "wake enable");
        rd(porm_pkg::ADDR_WAKE_EN, 32'h1000, OK, "wake enable");
        halt <= 1'h1;
        repeat (4) @(posedge mclk);
        pa_in <= 4'hF;
        repeat (8) @(posedge mclk);
        pins("pins in halt", 16'hFC6B);
        chk("wake masked", 32'h0, {31'h0, wake_req});
        pe_in <= 4'hE;
        repeat (8) @(posedge mclk);
        pins("pins in halt", 16'hFC6B);
        chk("wake enabled", 32'h1, {31'h0, wake_req});
        halt <= 1'h0;
        repeat (2) @(posedge mclk);
        pins("pins after halt", 16'hFC6B);
        chk("wake after halt", 32'h0, {31'h0, wake_req});
        rd(porm_pkg::ADDR_PADS, 32'h0002_E00F, OK, "pad levels");
        // Lane 0 strobe low writes zero into the port C and D latch
        s_axi_wstrb <= 4'hE;
        wr(porm_pkg::ADDR_CD_DATA, 32'hFF, OK, "strobed write");
        pins("pins strobed", 16'hFC4A);
        conclude();
    end
endmodule

// [verilog/porm_pkg.sv]
/*
 * Constants, register map and option layout for the port option and
 * read-multiplexer block of a small 4-bit controller.
 * Assumes a 32-bit AXI4-Lite register bus and one 10 MHz system clock.
 */
package porm_pkg;

    localparam int NIB = 4;
    localparam int DW  = 32;
    localparam int AW  = 8;

    // Register byte addresses
    localparam logic [AW-1:0] ADDR_OPTION  = 8'h00;
    localparam logic [AW-1:0] ADDR_E_DIR   = 8'h04;
    localparam logic [AW-1:0] ADDR_E_DATA  = 8'h08;
    localparam logic [AW-1:0] ADDR_CD_DATA = 8'h0C;
    localparam logic [AW-1:0] ADDR_WAKE_EN = 8'h10;
    localparam logic [AW-1:0] ADDR_PADS    = 8'h14;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Option register layout, lowest field at bit 0
    typedef struct packed {
        logic [NIB-1:0] port_d_force_high_option;
        logic [NIB-1:0] port_c_force_high_option;
        logic           port_e_bidir_option;
        logic           bit3_read_zero_option;
        logic           bit1_read_zero_option;
        logic           comparator_two_option;
        logic           comparator_one_option;
        logic           opamp_option;
    } porm_opt_s;
    localparam int OPT_W = $bits(porm_opt_s);
    localparam logic [OPT_W-1:0] OPT_RESET = 14'h0000;

    // Wake enable layout: A in [3:0], B [7:4], D [11:8], E [15:12]
    typedef struct packed {
        logic [NIB-1:0] port_e_wake_enable;
        logic [NIB-1:0] port_d_wake_enable;
        logic [NIB-1:0] port_b_wake_enable;
        logic [NIB-1:0] port_a_wake_enable;
    } porm_wake_s;
    localparam int WAKE_W = $bits(porm_wake_s);

    // Synchronised inputs: pads A,B,D,E then comparators one and two
    typedef struct packed {
        logic           cmp2;
        logic           cmp1;
        logic [NIB-1:0] pe;
        logic [NIB-1:0] pd;
        logic [NIB-1:0] pb;
        logic [NIB-1:0] pa;
    } porm_in_s;
    localparam int IN_W = $bits(porm_in_s);

    // Port C and D output latch: C in [3:0], D in [7:4]
    typedef struct packed {
        logic [NIB-1:0] pd;
        logic [NIB-1:0] pc;
    } porm_cd_s;
    localparam int CD_W = $bits(porm_cd_s);

    localparam logic [NIB-1:0] NIB_ZERO = 4'h0;
    localparam logic [DW-1:0]  WORD_ZERO = 32'h0000_0000;

endpackage

// [verilog/porm_port_option_read_mux.sv]
/*
 * Port option logic: port E read multiplexer, port E direction and
 * output latch, port C/D force-high outputs, per-pin halt wake-up,
 * all reached over an AXI4-Lite slave.
 * Assumes pads and comparator outputs are asynchronous to mclk, and
 * that software writes the option register once before operation.
 */
`timescale 1ns/1ps
module porm_port_option_read_mux (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // AXI4-Lite slave
    input  wire logic [porm_pkg::AW-1:0]    s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [porm_pkg::DW-1:0]    s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [porm_pkg::AW-1:0]    s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [porm_pkg::DW-1:0]         s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Pads and analog outputs
    input  wire logic [porm_pkg::NIB-1:0]   pa_in,
    input  wire logic [porm_pkg::NIB-1:0]   pb_in,
    input  wire logic [porm_pkg::NIB-1:0]   pd_in,
    input  wire logic [porm_pkg::NIB-1:0]   pe_in,
    input  wire logic                       cmp1_out,
    input  wire logic                       cmp2_out,
    output logic [porm_pkg::NIB-1:0]        pe_out,
    output logic [porm_pkg::NIB-1:0]        pe_oe_n,
    output logic [porm_pkg::NIB-1:0]        pc_out,
    output logic [porm_pkg::NIB-1:0]        pd_out,
    // Halt handshake with the core
    input  wire logic                       halt,
    output logic                            wake_req
);

    // Register state
    porm_pkg::porm_opt_s                opt, next_opt;
    logic [porm_pkg::NIB-1:0]           e_dir, next_e_dir;
    logic [porm_pkg::NIB-1:0]           e_latch, next_e_latch;
    porm_pkg::porm_cd_s                 cd_latch, next_cd_latch;
    porm_pkg::porm_wake_s               wake_en, next_wake_en;

    // Bus state
    logic                               aw_full, next_aw_full;
    logic                               w_full, next_w_full;
    logic [porm_pkg::AW-1:0]            aw_addr, next_aw_addr;
    logic [porm_pkg::DW-1:0]            w_data, next_w_data;
    logic [3:0]                         w_strb, next_w_strb;
    logic                               bvalid, next_bvalid;
    logic [1:0]                         bresp, next_bresp;
    logic                               rvalid, next_rvalid;
    logic [1:0]                         rresp, next_rresp;
    logic [porm_pkg::DW-1:0]            rdata, next_rdata;

    // Input synchronisers and filtered levels
    porm_pkg::porm_in_s                 sync1, sync2, sync3, lvl, next_lvl;
    porm_pkg::porm_in_s                 raw_in;

    // Outputs and wake-up state
    logic [porm_pkg::NIB-1:0]           next_pe_out, next_pe_oe_n, next_pc_out, next_pd_out;
    porm_pkg::porm_in_s                 snap, next_snap;
    logic                               next_wake_req;

    logic [porm_pkg::NIB-1:0]           e_read;
    logic                               do_write;
    logic [porm_pkg::DW-1:0]            wmask;

    // Pack raw asynchronous inputs
    assign raw_in = '{cmp2: cmp2_out, cmp1: cmp1_out, pe: pe_in, pd: pd_in, pb: pb_in, pa: pa_in};

    // Three-stage synchroniser; level moves once stages two and three agree
    always_comb begin
        next_lvl = lvl;
        for (int i = 0; i < porm_pkg::IN_W; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_lvl[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            lvl   <= '0;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl   <= next_lvl;
        end
    end

    // Port E read multiplexer, purely from static options
    always_comb begin
        e_read = lvl.pe;
        if (opt.opamp_option && opt.comparator_one_option && !opt.comparator_two_option) begin
            e_read[3] = 1'b0;
            e_read[2] = 1'b0;
            e_read[1] = opt.bit1_read_zero_option ? 1'b0 : lvl.pe[1];
            e_read[0] = lvl.cmp1;
        end else begin
            if (opt.comparator_one_option) begin
                e_read[1] = opt.bit1_read_zero_option ? 1'b0 : lvl.pe[1];
                e_read[0] = lvl.cmp1;
            end
            if (opt.comparator_two_option) begin
                e_read[3] = opt.bit3_read_zero_option ? 1'b0 : lvl.pe[3];
                e_read[2] = lvl.cmp2;
            end
        end
    end

    // Byte-lane mask of the pending write
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = w_strb[b] ? 8'hFF : 8'h00;
        end
    end

    assign do_write = aw_full && w_full && !bvalid;

    // AXI write and read channel sequencing plus register updates
    always_comb begin
        logic [porm_pkg::DW-1:0] merged;
        merged        = WORD_SEL(w_data, wmask);
        next_aw_full  = aw_full;
        next_w_full   = w_full;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rresp    = rresp;
        next_rdata    = rdata;
        next_opt      = opt;
        next_e_dir    = e_dir;
        next_e_latch  = e_latch;
        next_cd_latch = cd_latch;
        next_wake_en  = wake_en;

        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = porm_pkg::RESP_OKAY;
            unique case (aw_addr)
                porm_pkg::ADDR_OPTION:  next_opt = porm_pkg::porm_opt_s'(merged[porm_pkg::OPT_W-1:0]);
                porm_pkg::ADDR_E_DIR:   next_e_dir = merged[porm_pkg::NIB-1:0];
                porm_pkg::ADDR_E_DATA:  next_e_latch = merged[porm_pkg::NIB-1:0];
                porm_pkg::ADDR_CD_DATA: next_cd_latch = porm_pkg::porm_cd_s'(merged[porm_pkg::CD_W-1:0]);
                porm_pkg::ADDR_WAKE_EN: next_wake_en = porm_pkg::porm_wake_s'(merged[porm_pkg::WAKE_W-1:0]);
                porm_pkg::ADDR_PADS:    next_bresp = porm_pkg::RESP_OKAY;
                default:                next_bresp = porm_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = porm_pkg::RESP_OKAY;
            next_rdata  = porm_pkg::WORD_ZERO;
            unique case (s_axi_araddr)
                porm_pkg::ADDR_OPTION:  next_rdata[porm_pkg::OPT_W-1:0] = opt;
                porm_pkg::ADDR_E_DIR:   next_rdata[porm_pkg::NIB-1:0] = e_dir;
                porm_pkg::ADDR_E_DATA:  next_rdata[porm_pkg::NIB-1:0] = e_read;
                porm_pkg::ADDR_CD_DATA: next_rdata[porm_pkg::CD_W-1:0] = cd_latch;
                porm_pkg::ADDR_WAKE_EN: next_rdata[porm_pkg::WAKE_W-1:0] = wake_en;
                porm_pkg::ADDR_PADS:    next_rdata[porm_pkg::IN_W-1:0] = lvl;
                default:                next_rresp = porm_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Lane merge of write data over the old value is not needed: fields
    // outside enabled lanes read as zero in the merged word
    function automatic logic [porm_pkg::DW-1:0] WORD_SEL(input logic [porm_pkg::DW-1:0] d,
                                                        input logic [porm_pkg::DW-1:0] m);
        WORD_SEL = d & m;
    endfunction

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;

    // Pin drivers and wake-up detection
    always_comb begin
        // output only when bidirectional and direction set
        for (int i = 0; i < porm_pkg::NIB; i++) begin
            next_pe_oe_n[i] = !(opt.port_e_bidir_option && e_dir[i]);
        end
        next_pe_out = e_latch;
        next_pc_out = cd_latch.pc | opt.port_c_force_high_option;
        next_pd_out = cd_latch.pd | opt.port_d_force_high_option;
        // Snapshot follows pins outside halt
        next_snap = halt ? snap : lvl;
        // only enabled pins that moved end halt
        next_wake_req = halt && |({wake_en.port_e_wake_enable & (lvl.pe ^ snap.pe),
                                   wake_en.port_d_wake_enable & (lvl.pd ^ snap.pd),
                                   wake_en.port_b_wake_enable & (lvl.pb ^ snap.pb),
                                   wake_en.port_a_wake_enable & (lvl.pa ^ snap.pa)});
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            opt      <= porm_pkg::OPT_RESET;
            e_dir    <= porm_pkg::NIB_ZERO;
            e_latch  <= porm_pkg::NIB_ZERO;
            cd_latch <= '0;
            wake_en  <= '0;
            aw_full  <= 1'b0;
            w_full   <= 1'b0;
            aw_addr  <= '0;
            w_data   <= porm_pkg::WORD_ZERO;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= porm_pkg::RESP_OKAY;
            rvalid   <= 1'b0;
            rresp    <= porm_pkg::RESP_OKAY;
            rdata    <= porm_pkg::WORD_ZERO;
            pe_out   <= porm_pkg::NIB_ZERO;
            pe_oe_n  <= 4'hF;
            pc_out   <= porm_pkg::NIB_ZERO;
            pd_out   <= porm_pkg::NIB_ZERO;
            snap     <= '0;
            wake_req <= 1'b0;
        end else begin
            opt      <= next_opt;
            e_dir    <= next_e_dir;
            e_latch  <= next_e_latch;
            cd_latch <= next_cd_latch;
            wake_en  <= next_wake_en;
            aw_full  <= next_aw_full;
            w_full   <= next_w_full;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
            pe_out   <= next_pe_out;
            pe_oe_n  <= next_pe_oe_n;
            pc_out   <= next_pc_out;
            pd_out   <= next_pd_out;
            snap     <= next_snap;
            wake_req <= next_wake_req;
        end
    end

endmodule
